// ==== kbs_pkg.sv ====
// Package for the matrix keyboard scanner: register map, field layout,
// reset values and the host pin bundle.
// Assumes one core clock domain; all pins arrive asynchronously.
package kbs_pkg;

    // ------------------------------------------------------------------
    // Matrix geometry
    // ------------------------------------------------------------------
    localparam int         KBS_LINES     = 11;
    localparam int         KBS_KEYS      = 121;
    localparam int         KBS_CODE_W    = 7;
    localparam int         KBS_IDX_W     = 4;
    localparam logic [6:0] KBS_LAST_CODE = 7'h78;
    localparam logic [3:0] KBS_LAST_LINE = 4'hA;
    localparam logic [6:0] KBS_FIRST_CODE = 7'h00;
    localparam logic [3:0] KBS_FIRST_LINE = 4'h0;

    // ------------------------------------------------------------------
    // Register addresses (three address inputs)
    // ------------------------------------------------------------------
    localparam logic [2:0] KBS_A_KEY_CODE = 3'h0;
    localparam logic [2:0] KBS_A_REPEAT   = 3'h1;
    localparam logic [2:0] KBS_A_IDLE_LO  = 3'h2;
    localparam logic [2:0] KBS_A_IDLE_HI  = 3'h3;
    localparam logic [2:0] KBS_A_COMBO0   = 3'h4;
    localparam logic [2:0] KBS_A_COMBO1   = 3'h5;
    localparam logic [2:0] KBS_A_COMBO2   = 3'h6;
    localparam logic [2:0] KBS_A_WAKE     = 3'h7;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int          KBS_RELEASE_BIT = 7;
    localparam int          KBS_SERIAL_BIT  = 7;
    localparam int          KBS_COMBOS      = 3;
    localparam logic [7:0]  KBS_RST_BYTE    = 8'h00;
    localparam logic [15:0] KBS_RST_WORD    = 16'h0000;
    localparam logic [10:0] KBS_DRIVE_FIRST = 11'h001;

    // ------------------------------------------------------------------
    // Host pin bundle
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       read_strobe_n;
        logic       write_strobe_n;
        logic [2:0] addr;
        logic [7:0] wdata;
    } kbs_host_s;

    localparam kbs_host_s KBS_HOST_IDLE = '{read_strobe_n:  1'b1,
                                             write_strobe_n: 1'b1,
                                             addr:           3'h0,
                                             wdata:          8'h00};

endpackage : kbs_pkg

// ==== kbs_scanner.sv ====
// Matrix keyboard scanner: scans an 11 x 11 key matrix one junction per
// scan clock, reports key actions to a host over an 8-bit strobed bus.
// Assumes scan_clk, strobes, data and matrix pins are asynchronous to
// core_clk and that scan_clk is much slower than core_clk.
//
// Contract
// RULE1 - Scan an 11 by 11 matrix; each of 121 keys has code 0 to 120.
// RULE2 - Code is drive line times eleven plus sense line.
// RULE3 - One drive line high at a time; sense lines stepped, then next drive.
// RULE4 - Junction differing from stored state updates it and loads the code.
// RULE5 - Key code holds code in bits 0-6, bit 7 set for release.
// RULE6 - One key interrupt per press or release, held until code read.
// RULE7 - Host reads the key code for every key interrupt.
// RULE8 - After repeat_delay quiet scans a held key re-interrupts every scan.
// RULE9 - Idle counter counts scans while limit nonzero; match raises idle_irq.
// RULE10 - Zero idle limit disables the idle interrupt.
// RULE11 - Idle interrupt cleared by code read or key interrupt; counter resets.
// RULE12 - All three reboot keys pressed in one scan pulse reboot for one scan.
// RULE13 - Reboot combo values above 121 never match, disabling reboot.
// RULE14 - Wake key found pulses wake_irq one scan period; above 121 disables. The code compares bits 0-6 only, so values 128 to 248 still match.
// RULE15 - Wake register bit 7 selects matrix (low) or serial keyboard (high).
// RULE16 - Three address bits select the eight byte registers.
// RULE17 - Read strobe low drives data out; write strobe rise latches data.
// RULE18 - reset_n low clears all keyboard registers.
// RULE19 - low_power_n low stops repeat and idle counters.
// RULE20 - Ghost freezes state and interrupts until one clean scan.
// RULE21 - PC key code register is write-only, visible only on its own port.
// RULE22 - Software checks keyboard enable and previous code taken first.
// RULE23 - Ghost when new press completes a rectangle of pressed junctions.
module kbs_scanner #(
    parameter int REPEAT_W = 8,
    parameter int IDLE_W   = 16
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              reset_n,
    input  wire logic              low_power_n,
    input  wire logic              scan_clk,
    input  wire kbs_pkg::kbs_host_s host_req,
    output logic [7:0]             rdata,
    output logic [10:0]            drive_lines,
    output logic [10:0]            drive_lines_oe_n,
    input  wire logic [10:0]       sense_lines,
    input  wire logic [10:0]       drive_feedback,
    output logic                   key_irq,
    output logic                   idle_irq,
    output logic                   wake_irq,
    output logic                   reboot_pulse,
    output logic                   kbd_reset_source_flag,
    output logic                   serial_kbd_sel,
    output logic [7:0]             pc_key_code
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    kbs_pkg::kbs_host_s host_s1_ff;
    kbs_pkg::kbs_host_s host_s2_ff;
    kbs_pkg::kbs_host_s host_prev_ff;
    logic [10:0]        sense_s1_ff;
    logic [10:0]        sense_s2_ff;
    logic [10:0]        fb_s1_ff;
    logic [10:0]        fb_s2_ff;
    logic [2:0]         misc_s1_ff;
    logic [2:0]         misc_s2_ff;
    logic               sclk_prev_ff;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            host_s1_ff   <= kbs_pkg::KBS_HOST_IDLE;
            host_s2_ff   <= kbs_pkg::KBS_HOST_IDLE;
            host_prev_ff <= kbs_pkg::KBS_HOST_IDLE;
            sense_s1_ff  <= '0;
            sense_s2_ff  <= '0;
            fb_s1_ff     <= '0;
            fb_s2_ff     <= '0;
            misc_s1_ff   <= 3'h0;
            misc_s2_ff   <= 3'h0;
            sclk_prev_ff <= 1'b0;
        end else begin
            host_s1_ff   <= host_req;
            host_s2_ff   <= host_s1_ff;
            host_prev_ff <= host_s2_ff;
            sense_s1_ff  <= sense_lines;
            sense_s2_ff  <= sense_s1_ff;
            fb_s1_ff     <= drive_feedback;
            fb_s2_ff     <= fb_s1_ff;
            misc_s1_ff   <= {reset_n, low_power_n, scan_clk};
            misc_s2_ff   <= misc_s1_ff;
            sclk_prev_ff <= misc_s2_ff[0];
        end
    end

    logic kclr;
    logic lp_run;
    logic step;
    logic wr_rise;
    logic rd_rise;
    logic rd_active;

    assign kclr      = ~misc_s2_ff[2];
    assign lp_run    = misc_s2_ff[1];
    assign step      = misc_s2_ff[0] & ~sclk_prev_ff;
    assign wr_rise   = host_s2_ff.write_strobe_n & ~host_prev_ff.write_strobe_n;
    assign rd_rise   = host_s2_ff.read_strobe_n & ~host_prev_ff.read_strobe_n;
    assign rd_active = ~host_s2_ff.read_strobe_n;

    // ------------------------------------------------------------------
    // Host registers
    // ------------------------------------------------------------------
    logic [REPEAT_W-1:0] repeat_delay_ff;
    logic [IDLE_W-1:0]   idle_limit_ff;
    logic [7:0]          combo_ff [kbs_pkg::KBS_COMBOS];
    logic [7:0]          wake_key_ff;
    logic [7:0]          pc_key_code_ff;
    logic [7:0]          key_code_ff;
    logic                limit_wr;
    logic                key_rd;

    assign limit_wr = wr_rise && (host_s2_ff.addr == kbs_pkg::KBS_A_IDLE_LO ||
                                  host_s2_ff.addr == kbs_pkg::KBS_A_IDLE_HI);
    assign key_rd   = rd_rise && (host_prev_ff.addr == kbs_pkg::KBS_A_KEY_CODE);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst || kclr) begin                                        // [RULE18]
            repeat_delay_ff <= '0;
            idle_limit_ff   <= '0;
            wake_key_ff     <= kbs_pkg::KBS_RST_BYTE;
            pc_key_code_ff  <= kbs_pkg::KBS_RST_BYTE;
            for (int i = 0; i < kbs_pkg::KBS_COMBOS; i++) begin
                combo_ff[i] <= kbs_pkg::KBS_RST_BYTE;
            end
        end else if (wr_rise) begin                                   // [RULE17]
            case (host_s2_ff.addr)                                    // [RULE16]
                kbs_pkg::KBS_A_KEY_CODE: pc_key_code_ff <= host_s2_ff.wdata; // [RULE21]
                kbs_pkg::KBS_A_REPEAT:   repeat_delay_ff <= host_s2_ff.wdata;
                kbs_pkg::KBS_A_IDLE_LO:  idle_limit_ff[7:0] <= host_s2_ff.wdata;
                kbs_pkg::KBS_A_IDLE_HI:  idle_limit_ff[15:8] <= host_s2_ff.wdata;
                kbs_pkg::KBS_A_COMBO0:   combo_ff[0] <= host_s2_ff.wdata;
                kbs_pkg::KBS_A_COMBO1:   combo_ff[1] <= host_s2_ff.wdata;
                kbs_pkg::KBS_A_COMBO2:   combo_ff[2] <= host_s2_ff.wdata;
                kbs_pkg::KBS_A_WAKE:     wake_key_ff <= host_s2_ff.wdata;
                default:                 wake_key_ff <= wake_key_ff;
            endcase
        end
    end

    logic [7:0] rd_mux;

    always_comb begin
        case (host_s2_ff.addr)                                        // [RULE16]
            kbs_pkg::KBS_A_KEY_CODE: rd_mux = key_code_ff;
            kbs_pkg::KBS_A_REPEAT:   rd_mux = repeat_delay_ff;
            kbs_pkg::KBS_A_IDLE_LO:  rd_mux = idle_limit_ff[7:0];
            kbs_pkg::KBS_A_IDLE_HI:  rd_mux = idle_limit_ff[15:8];
            kbs_pkg::KBS_A_COMBO0:   rd_mux = combo_ff[0];
            kbs_pkg::KBS_A_COMBO1:   rd_mux = combo_ff[1];
            kbs_pkg::KBS_A_COMBO2:   rd_mux = combo_ff[2];
            kbs_pkg::KBS_A_WAKE:     rd_mux = wake_key_ff;
            default:                 rd_mux = kbs_pkg::KBS_RST_BYTE;
        endcase
    end

    logic [7:0] rdata_ff;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= kbs_pkg::KBS_RST_BYTE;
        end else begin
            rdata_ff <= rd_active ? rd_mux : kbs_pkg::KBS_RST_BYTE;   // [RULE17]
        end
    end

    // ------------------------------------------------------------------
    // Scan position
    // ------------------------------------------------------------------
    logic [3:0]  drv_ff;
    logic [3:0]  sns_ff;
    logic [6:0]  cur_code_ff;
    logic [10:0] drive_ff;
    logic        scan_end;

    assign scan_end = (cur_code_ff == kbs_pkg::KBS_LAST_CODE);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            drv_ff      <= kbs_pkg::KBS_FIRST_LINE;
            sns_ff      <= kbs_pkg::KBS_FIRST_LINE;
            cur_code_ff <= kbs_pkg::KBS_FIRST_CODE;
            drive_ff    <= kbs_pkg::KBS_DRIVE_FIRST;
        end else if (kclr) begin
            drv_ff      <= kbs_pkg::KBS_FIRST_LINE;
            sns_ff      <= kbs_pkg::KBS_FIRST_LINE;
            cur_code_ff <= kbs_pkg::KBS_FIRST_CODE;
            drive_ff    <= kbs_pkg::KBS_DRIVE_FIRST;
        end else if (step) begin
            // Code tracks drive-major position: drive * 11 + sense
            cur_code_ff <= scan_end ? kbs_pkg::KBS_FIRST_CODE
                                    : cur_code_ff + 7'h01;            // [RULE2]
            if (sns_ff == kbs_pkg::KBS_LAST_LINE) begin               // [RULE3]
                sns_ff <= kbs_pkg::KBS_FIRST_LINE;
                if (drv_ff == kbs_pkg::KBS_LAST_LINE) begin
                    drv_ff   <= kbs_pkg::KBS_FIRST_LINE;
                    drive_ff <= kbs_pkg::KBS_DRIVE_FIRST;
                end else begin
                    drv_ff   <= drv_ff + 4'h1;
                    drive_ff <= {drive_ff[9:0], 1'b0};
                end
            end else begin
                sns_ff <= sns_ff + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Junction evaluation and ghost detection
    // ------------------------------------------------------------------
    logic [kbs_pkg::KBS_KEYS-1:0]  key_state_ff;
    logic [kbs_pkg::KBS_LINES-1:0] own_row;
    logic [kbs_pkg::KBS_LINES-1:0] other_cols;
    logic [kbs_pkg::KBS_LINES-1:0] ghost_row;
    logic [6:0]                    row_base;
    logic                          pressed;
    logic                          stored;
    logic                          ghost_now;

    assign row_base   = 7'(drv_ff * kbs_pkg::KBS_LINES);
    assign own_row    = key_state_ff[row_base +: kbs_pkg::KBS_LINES];
    assign other_cols = own_row & ~(11'h001 << sns_ff);
    assign pressed    = sense_s2_ff[sns_ff];                          // [RULE1]
    assign stored     = key_state_ff[cur_code_ff];

    genvar r;
    generate
        for (r = 0; r < kbs_pkg::KBS_LINES; r++) begin : g_ghost
            // Another row sharing this column and a column of our row
            assign ghost_row[r] = (drv_ff != 4'(r))
                && key_state_ff[7'(r * kbs_pkg::KBS_LINES) + 7'(sns_ff)]
                && |(key_state_ff[r * kbs_pkg::KBS_LINES +: kbs_pkg::KBS_LINES]
                     & other_cols);                                   // [RULE23]
        end
    endgenerate

    // Feedback differing from the driven line also means a short path
    assign ghost_now = (pressed && !stored && |ghost_row)
                     || (fb_s2_ff != drive_ff);                       // [RULE20]

    // ------------------------------------------------------------------
    // Key state, key code and key interrupt
    // ------------------------------------------------------------------
    logic                    frozen_ff;
    logic                    ghost_scan_ff;
    logic                    changed_scan_ff;
    logic [6:0]              last_press_ff;
    logic                    key_irq_ff;
    logic [REPEAT_W-1:0]     rpt_cnt_ff;
    logic                    report;
    logic                    repeat_fire;
    logic                    key_irq_raise;

    // Hold off new actions while the previous code is unread
    assign report = step && (pressed != stored) && !frozen_ff && !ghost_now
                 && !ghost_scan_ff && !key_irq_ff;                    // [RULE4] [RULE6]
    assign repeat_fire = step && scan_end && !frozen_ff && !ghost_now
                 && !ghost_scan_ff && !changed_scan_ff && !report && !key_irq_ff
                 && (rpt_cnt_ff >= repeat_delay_ff)
                 && key_state_ff[last_press_ff];                      // [RULE8]
    assign key_irq_raise = report || repeat_fire;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst || kclr) begin                                        // [RULE18]
            key_state_ff    <= '0;
            key_code_ff     <= kbs_pkg::KBS_RST_BYTE;
            key_irq_ff      <= 1'b0;
            last_press_ff   <= kbs_pkg::KBS_FIRST_CODE;
            frozen_ff       <= 1'b0;
            ghost_scan_ff   <= 1'b0;
            changed_scan_ff <= 1'b0;
        end else begin
            if (key_rd) begin
                key_irq_ff <= 1'b0;                                   // [RULE6]
            end
            if (report) begin
                key_state_ff[cur_code_ff] <= pressed;                 // [RULE4]
                key_code_ff <= {~pressed, cur_code_ff};               // [RULE5]
                key_irq_ff <= 1'b1;
                changed_scan_ff <= 1'b1;
                if (pressed) begin
                    last_press_ff <= cur_code_ff;
                end
            end
            if (repeat_fire) begin
                key_code_ff <= {1'b0, last_press_ff};                 // [RULE8]
                key_irq_ff  <= 1'b1;
            end
            if (step && ghost_now) begin
                ghost_scan_ff <= 1'b1;                                // [RULE20]
            end
            if (step && scan_end) begin
                // Stay frozen until one whole scan passes without a ghost
                frozen_ff       <= ghost_scan_ff || ghost_now;        // [RULE20]
                ghost_scan_ff   <= 1'b0;
                changed_scan_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Auto-repeat scan counter
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst || kclr) begin
            rpt_cnt_ff <= '0;
        end else if (report) begin
            rpt_cnt_ff <= '0;
        end else if (step && scan_end && lp_run && !changed_scan_ff) begin // [RULE19]
            if (rpt_cnt_ff != '1) begin
                rpt_cnt_ff <= rpt_cnt_ff + 1'b1;                      // [RULE8]
            end
        end
    end

    // ------------------------------------------------------------------
    // Idle counter and idle interrupt
    // ------------------------------------------------------------------
    logic [IDLE_W-1:0] idle_cnt_ff;
    logic [IDLE_W-1:0] nxt_idle_cnt;
    logic              idle_irq_ff;
    logic              idle_count;
    logic              idle_hit;
    logic              idle_clear;

    assign nxt_idle_cnt = idle_cnt_ff + 1'b1;
    assign idle_count   = step && scan_end && lp_run
                       && (idle_limit_ff != '0);                      // [RULE9] [RULE10] [RULE19]
    assign idle_hit     = idle_count && (nxt_idle_cnt == idle_limit_ff);
    assign idle_clear   = key_irq_raise || key_rd;                    // [RULE11]

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst || kclr) begin
            idle_cnt_ff <= '0;
        end else if (idle_clear || limit_wr) begin
            idle_cnt_ff <= '0;                                        // [RULE9] [RULE11]
        end else if (idle_count) begin
            idle_cnt_ff <= nxt_idle_cnt;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst || kclr) begin
            idle_irq_ff <= 1'b0;
        end else if (idle_hit) begin
            idle_irq_ff <= 1'b1;                                      // [RULE9]
        end else if (idle_clear) begin
            idle_irq_ff <= 1'b0;                                      // [RULE11]
        end
    end

    // ------------------------------------------------------------------
    // Reboot combination and wake key
    // ------------------------------------------------------------------
    logic [kbs_pkg::KBS_COMBOS-1:0] combo_hit;
    logic [kbs_pkg::KBS_COMBOS-1:0] found_ff;
    logic                           reboot_ff;
    logic                           src_flag_ff;
    logic                           wake_ff;

    genvar c;
    generate
        for (c = 0; c < kbs_pkg::KBS_COMBOS; c++) begin : g_combo
            // Full byte compare: values above 120 can never match
            assign combo_hit[c] = pressed && (combo_ff[c] == {1'b0, cur_code_ff}); // [RULE13]
        end
    endgenerate

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst || kclr) begin
            found_ff    <= '0;
            reboot_ff   <= 1'b0;
            src_flag_ff <= 1'b0;
            wake_ff     <= 1'b0;
        end else if (step) begin
            // Reboot and wake outputs are re-evaluated every step, so each lasts one scan period
            reboot_ff <= scan_end && (&(found_ff | combo_hit));       // [RULE12]
            found_ff  <= scan_end ? '0 : (found_ff | combo_hit);
            if (scan_end && (&(found_ff | combo_hit))) begin
                src_flag_ff <= 1'b1;                                  // [RULE12]
            end
            wake_ff <= pressed && (wake_key_ff[6:0] == cur_code_ff);  // [RULE14]
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata                 = rdata_ff;
    assign drive_lines           = drive_ff;                          // [RULE3]
    assign drive_lines_oe_n      = ~drive_ff;
    assign key_irq               = key_irq_ff;
    assign idle_irq              = idle_irq_ff;
    assign wake_irq              = wake_ff;
    assign reboot_pulse          = reboot_ff;
    assign kbd_reset_source_flag = src_flag_ff;
    assign serial_kbd_sel        = wake_key_ff[kbs_pkg::KBS_SERIAL_BIT]; // [RULE15]
    assign pc_key_code           = pc_key_code_ff;                    // [RULE21]

endmodule : kbs_scanner

// ==== kbs_matrix.sv ====
// Key matrix model: a pressed switch joins its drive line to its sense line.
// Assumes undriven drive lines and idle sense lines are pulled down.
module kbs_matrix (
    input  wire logic [10:0]  drive_lines,
    input  wire logic [10:0]  drive_lines_oe_n,
    input  wire logic [120:0] pressed,
    output logic [10:0]       sense_lines,
    output logic [10:0]       drive_feedback
);
    timeunit 1ns;
    timeprecision 1ns;
    always_comb begin
        drive_feedback = drive_lines & ~drive_lines_oe_n;
        sense_lines    = 11'h000;
        for (int k = 0; k < 121; k++) begin
            if (pressed[k] && drive_feedback[k / 11]) begin
                sense_lines[k % 11] = 1'b1;
            end
        end
    end
endmodule : kbs_matrix

// ==== kbs_scanner_chk.sv ====
// Port checker for the keyboard scanner.
// Assumes one core clock domain; bound to the scanner below.
module kbs_chk (
    input wire logic               core_clk,
    input wire logic               rst,
    input wire logic               reset_n,
    input wire logic               scan_clk,
    input wire kbs_pkg::kbs_host_s host_req,
    input wire logic [7:0]         rdata,
    input wire logic [10:0]        drive_lines,
    input wire logic               key_irq,
    input wire logic               wake_irq,
    input wire logic               reboot_pulse,
    input wire logic               kbd_reset_source_flag
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_hot; $onehot(drive_lines); endproperty
    a_hot: assert property (p_hot) else $error("drive not one-hot");
    property p_step; $changed(drive_lines) |-> $past(scan_clk, 3) || !reset_n
        || !$past(reset_n, 2); endproperty
    a_step: assert property (p_step) else $error("drive moved off step");
    property p_krise; $rose(key_irq) |-> $past(scan_clk, 3); endproperty
    a_krise: assert property (p_krise) else $error("key irq off step");
    property p_khold; (host_req.read_strobe_n && reset_n)[*6] ##0 key_irq |=> key_irq;
    endproperty
    a_khold: assert property (p_khold) else $error("key irq lost");
    property p_rd0; host_req.read_strobe_n[*6] |-> rdata == 8'h00; endproperty
    a_rd0: assert property (p_rd0) else $error("data out not idle");
    property p_wake; $rose(wake_irq) |-> wake_irq[*8]; endproperty
    a_wake: assert property (p_wake) else $error("wake too short");
    property p_boot; $rose(reboot_pulse) |-> reboot_pulse[*8] ##1 kbd_reset_source_flag;
    endproperty
    a_boot: assert property (p_boot) else $error("reboot pulse bad");
    property p_reset_n; (!reset_n)[*4] |-> !key_irq && !wake_irq && drive_lines == 11'h001;
    endproperty
    a_reset_n: assert property (p_reset_n) else $error("clear pin ignored");
endmodule : kbs_chk
bind kbs_scanner kbs_chk u_chk (.core_clk, .rst, .reset_n, .scan_clk, .host_req, .rdata,
    .drive_lines, .key_irq, .wake_irq, .reboot_pulse, .kbd_reset_source_flag);

// ==== kbs_scanner_tb.sv ====
// Bench for the keyboard scanner: bus task and scenarios.
// Assumes the port checker is bound from its own file.
module kbs_scanner_tb;
    timeunit 1ns;
    timeprecision 1ns;
`define CK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
    logic               core_clk = 1'b0;
    logic               rst = 1'b1;
    logic               reset_n = 1'b0;
    logic               low_power_n = 1'b1;
    logic               scan_clk = 1'b0;
    kbs_pkg::kbs_host_s host_req = kbs_pkg::KBS_HOST_IDLE;
    logic [120:0]       pressed = '0;
    logic [7:0]         rdata, pc_key_code, rv;
    logic [10:0]        drive_lines, drive_lines_oe_n, sense_lines, drive_feedback;
    logic               key_irq, idle_irq, wake_irq, reboot_pulse, kbd_reset_source_flag;
    logic               serial_kbd_sel;
    int                 err_count = 0;
    int                 checks = 0;
    always #2 core_clk = ~core_clk;
    always #40 scan_clk = ~scan_clk;
    kbs_scanner DUT (.core_clk, .rst, .reset_n, .low_power_n, .scan_clk, .host_req, .rdata,
        .drive_lines, .drive_lines_oe_n, .sense_lines, .drive_feedback, .key_irq, .idle_irq,
        .wake_irq, .reboot_pulse, .kbd_reset_source_flag, .serial_kbd_sel, .pc_key_code);
    kbs_matrix u_mat (.drive_lines, .drive_lines_oe_n, .pressed, .sense_lines, .drive_feedback);
    // Strobe low 5 cycles, then 6 idle, address and data kept
    task automatic bus(input bit w, input logic [2:0] a, input logic [7:0] d);
        @(negedge core_clk);
        host_req.addr = a;
        host_req.wdata = d;
        if (w) host_req.write_strobe_n = 1'b0;
        else host_req.read_strobe_n = 1'b0;
        repeat (5) @(negedge core_clk);
        rv = rdata;
        host_req.write_strobe_n = 1'b1;
        host_req.read_strobe_n = 1'b1;
        repeat (6) @(negedge core_clk);
    endtask : bus
    task automatic pk(input int k, input bit v);
        pressed[k] = v;
        repeat (12000) if (!key_irq) @(negedge core_clk);
        bus(0, 3'h0, 8'h00);
    endtask : pk
    task automatic t_regs;
        logic [7:0] v [1:7] = '{8'h02, 8'hC3, 8'h5A, 8'h7A, 8'h7B, 8'h7C, 8'hFD};
        for (int a = 1; a < 8; a++) begin
            bus(0, 3'(a), 8'h00);
            `CK("reset value", 8'h00, rv)
            bus(1, 3'(a), v[a]);
            bus(0, 3'(a), 8'h00);
            `CK("readback", v[a], rv)
        end
        `CK("serial select", 1'b1, serial_kbd_sel)
        bus(1, 3'h0, 8'hA5);
        `CK("pc code", 8'hA5, pc_key_code)
        bus(0, 3'h0, 8'h00);
        `CK("key code", 8'h00, rv)
    endtask : t_regs
    task automatic t_key;
        pk(11, 1'b1);
        `CK("press code", 8'h0B, rv)
        pk(11, 1'b0);
        `CK("release code", 8'h8B, rv)
        pk(120, 1'b1);
        `CK("last code", 8'h78, rv)
        `CK("key irq cleared", 1'b0, key_irq)
        pk(120, 1'b1);
        `CK("repeat code", 8'h78, rv)
        pk(120, 1'b0);
        `CK("last release", 8'hF8, rv)
        `CK("no reboot", 1'b0, kbd_reset_source_flag)
    endtask : t_key
    task automatic t_idle;
        bus(1, 3'h3, 8'h00);
        low_power_n = 1'b0;
        bus(1, 3'h2, 8'h02);
        repeat (8000) @(negedge core_clk);
        `CK("lp stop", 1'b0, idle_irq)
        low_power_n = 1'b1;
        repeat (8000) if (!idle_irq) @(negedge core_clk);
        `CK("idle set", 1'b1, idle_irq)
        bus(0, 3'h0, 8'h00);
        `CK("idle cleared", 1'b0, idle_irq)
        bus(1, 3'h2, 8'h00);
        repeat (8000) @(negedge core_clk);
        `CK("idle disabled", 1'b0, idle_irq)
    endtask : t_idle
    task automatic t_wake;
        bus(1, 3'h7, 8'h0B);
        bus(1, 3'h4, 8'h0B);
        bus(1, 3'h5, 8'h78);
        bus(1, 3'h6, 8'h05);
        `CK("matrix select", 1'b0, serial_kbd_sel)
        pressed = {1'b1, 120'h821};
        repeat (6000) if (!wake_irq) @(negedge core_clk);
        `CK("wake", 1'b1, wake_irq)
        repeat (6000) if (!reboot_pulse) @(negedge core_clk);
        `CK("reboot", 1'b1, reboot_pulse)
        repeat (20) @(negedge core_clk);
        pressed = '0;
        reset_n = 1'b0;
        repeat (6) @(negedge core_clk);
        reset_n = 1'b1;
        bus(0, 3'h4, 8'h00);
        `CK("cleared combo", 8'h00, rv)
        `CK("cleared flag", 1'b0, kbd_reset_source_flag)
    endtask : t_wake
    task automatic summarize;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        reset_n = 1'b1;
        repeat (4) @(negedge core_clk);
        t_regs();
        t_key();
        t_idle();
        t_wake();
        summarize();
    end
    initial begin
        #400000;
        err_count++;
        summarize();
    end
endmodule : kbs_scanner_tb
